/* src/wcb_pkg.sv */
// wcb_pkg: constants and types shared by the write-combining unit
// assumes: one clock domain, stores arrive one per cycle at most
package wcb_pkg;

  localparam int ADDR_W = 40;
  localparam int LINE_BYTES = 64;
  localparam int LINE_OFS_W = 6;
  localparam int LINE_W = ADDR_W - LINE_OFS_W;
  localparam int DATA_W = 64;
  localparam int LANE_W = 8;
  localparam int QW_PER_LINE = 8;
  localparam int QW_IDX_W = 3;
  localparam int NUM_BUF = 4;
  localparam int BUF_IDX_W = 2;
  localparam int FIFO_DEPTH = 8;
  localparam int CMD_DATA_W = 512;

  // store size codes, log2 of the byte count: byte, word, doubleword, quadword
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_WORD = 2'h1;
  localparam logic [1:0] SIZE_DWORD = 2'h2;
  localparam logic [1:0] SIZE_QWORD = 2'h3;

  localparam logic [63:0] MASK_FULL = 64'hffff_ffff_ffff_ffff;
  localparam logic [63:0] MASK_EMPTY = 64'h0;

  // memory types of a store
  typedef enum logic [2:0] {
    WCB_UNCACHEABLE_TYPE,
    WCB_WRITE_PROTECT_TYPE,
    WCB_WRITE_THROUGH_TYPE,
    WCB_WRITEBACK_TYPE,
    WCB_COMBINING_TYPE
  } wcb_mtype_e;

  // drain engine states
  typedef enum logic [1:0] {
    WCB_IDLE,
    WCB_PICK,
    WCB_EMIT
  } wcb_state_e;

endpackage : wcb_pkg

/* src/wcb_fifo.sv */
// wcb_fifo: synchronous valid/ready FIFO for outgoing write commands
// assumes: same clock as the producer and consumer, asynchronous reset
`timescale 1ns/1ps
module wcb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [PTR_W:0] count, next_count;
  logic push, pop;

  ////////////////////////////////////////////////////////////////////////////
  // flags come from the count, so full and empty never disagree
  assign in_ready = (count != (PTR_W + 1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and count arithmetic
  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // storage is not reset; only valid entries are ever read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule : wcb_fifo

/* src/wcb_unit.sv */
// wcb_unit: write-combining unit with four line-aligned 64-byte merge buffers
// assumes: stores and events are synchronous to clk; the caller holds a
// store until st_ready, and holds a closing event until its done level rises
`timescale 1ns/1ps

module wcb_unit #(
  parameter int NUM_BUF = wcb_pkg::NUM_BUF,
  parameter int FIFO_DEPTH = wcb_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  // store request
  input wire logic st_valid,
  output logic st_ready,
  input wire logic [wcb_pkg::ADDR_W-1:0] st_addr,
  input wire logic [1:0] st_size,
  input wire logic [wcb_pkg::DATA_W-1:0] st_data,
  input wire wcb_pkg::wcb_mtype_e st_type,
  input wire logic st_streaming,
  // read snoop
  input wire logic rd_valid,
  input wire logic [wcb_pkg::ADDR_W-1:0] rd_addr,
  input wire wcb_pkg::wcb_mtype_e rd_type,
  output logic rd_done,
  // closing events, level requests held until evt_done
  input wire logic evt_io,
  input wire logic evt_serialize,
  input wire logic evt_flush,
  input wire logic evt_lock,
  input wire logic evt_ad_set,
  output logic evt_done,
  // write commands to the interconnect
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic [wcb_pkg::LINE_W-1:0] cmd_line,
  output logic [wcb_pkg::LINE_BYTES-1:0] cmd_mask,
  output logic [wcb_pkg::CMD_DATA_W-1:0] cmd_data,
  output logic cmd_full_line,
  output logic [wcb_pkg::BUF_IDX_W:0] open_count
);

  localparam int IDX_W = wcb_pkg::BUF_IDX_W;
  localparam int CMD_W = wcb_pkg::LINE_W + wcb_pkg::LINE_BYTES + wcb_pkg::CMD_DATA_W + 1;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // byte-lane mask of a store within its line
  function automatic logic [63:0] lane_mask(input logic [5:0] ofs, input logic [1:0] size);
    logic [63:0] base;
    base = '0;
    case (size)
      wcb_pkg::SIZE_BYTE: base = 64'h1;
      wcb_pkg::SIZE_WORD: base = 64'h3;
      wcb_pkg::SIZE_DWORD: base = 64'hf;
      default: base = 64'hff;
    endcase
    return base << ofs;
  endfunction : lane_mask

  function automatic logic [wcb_pkg::LINE_W-1:0] line_of(input logic [wcb_pkg::ADDR_W-1:0] a);
    return a[wcb_pkg::ADDR_W-1:wcb_pkg::LINE_OFS_W];
  endfunction : line_of

  // streaming stores over writeback are combined like combining-type stores
  function automatic logic combinable(input wcb_pkg::wcb_mtype_e t, input logic strm);
    return (t == wcb_pkg::WCB_COMBINING_TYPE) ||
           (strm && t == wcb_pkg::WCB_WRITEBACK_TYPE);
  endfunction : combinable

  ////////////////////////////////////////////////////////////////////////////
  // buffer state: base line, byte mask, streaming flag, opening age, data
  logic buf_open [NUM_BUF];
  logic buf_closed [NUM_BUF];
  logic [wcb_pkg::LINE_W-1:0] buf_line [NUM_BUF];
  logic [63:0] buf_mask [NUM_BUF];
  logic buf_strm [NUM_BUF];
  logic [IDX_W:0] buf_age [NUM_BUF];
  logic [wcb_pkg::CMD_DATA_W-1:0] buf_data [NUM_BUF];
  logic next_open [NUM_BUF];
  logic next_closed [NUM_BUF];
  logic [wcb_pkg::LINE_W-1:0] next_line [NUM_BUF];
  logic [63:0] next_mask [NUM_BUF];
  logic next_strm [NUM_BUF];
  logic [IDX_W:0] next_buf_age [NUM_BUF];
  logic [wcb_pkg::CMD_DATA_W-1:0] next_data [NUM_BUF];

  // decoded store
  logic st_comb;
  logic [wcb_pkg::LINE_W-1:0] st_line;
  logic [63:0] st_lanes;
  logic [wcb_pkg::CMD_DATA_W-1:0] st_wide;
  logic hit_any, hit_conflict, free_any, any_open, busy;
  logic [IDX_W-1:0] hit_idx, free_idx, old_idx, st_dst;
  logic [IDX_W:0] n_busy;
  logic rd_hit, rd_needs_close, evt_any;
  logic st_take;
  logic fifo_in_valid, fifo_in_ready;

  assign st_comb = combinable(st_type, st_streaming);
  assign st_line = line_of(st_addr);
  assign st_lanes = lane_mask(st_addr[5:0], st_size);
  assign st_wide = {wcb_pkg::QW_PER_LINE{st_data}};
  assign evt_any = evt_io || evt_serialize || evt_flush || evt_lock || evt_ad_set;

  // lookup: line hit, free slot, oldest open or closed buffer
  always_comb begin
    hit_any = 1'b0;
    hit_conflict = 1'b0;
    hit_idx = '0;
    free_any = 1'b0;
    free_idx = '0;
    any_open = 1'b0;
    busy = 1'b0;
    old_idx = '0;
    rd_hit = 1'b0;
    n_busy = '0;
    for (int i = 0; i < NUM_BUF; i++) begin
      if (buf_open[i] || buf_closed[i]) begin
        // ages are ranks among busy buffers, so the smallest is the oldest
        if (!busy || buf_age[i] < buf_age[old_idx]) begin
          old_idx = IDX_W'(i);
        end
        busy = 1'b1;
        n_busy = n_busy + 1'b1;
      end
      if (buf_open[i]) begin
        any_open = 1'b1;
        if (buf_line[i] == st_line) begin
          hit_any = 1'b1;
          hit_idx = IDX_W'(i);
          hit_conflict = (buf_strm[i] != st_streaming) || !st_comb;
        end
        if (buf_line[i] == line_of(rd_addr)) begin
          rd_hit = 1'b1;
        end
      end else if (!buf_closed[i] && !free_any) begin
        free_any = 1'b1;
        free_idx = IDX_W'(i);
      end
    end
  end

  // uncacheable read always closes, combining read only on a line match
  assign rd_needs_close = rd_valid && ((rd_type == wcb_pkg::WCB_UNCACHEABLE_TYPE) ||
                          (rd_type == wcb_pkg::WCB_COMBINING_TYPE && rd_hit));

  // events complete only once no buffer is open or closed; reads wait for that only when they need a close
  assign evt_done = evt_any && !busy;
  assign rd_done = rd_valid && !(rd_needs_close && busy);

  // a store waits while a close drains, or when it hits no open buffer and every slot is taken;
  // non-combinable stores wait until the pool is empty, then bypass
  // a bypassing store also needs room in the command queue, or it would be lost
  assign st_ready = !evt_any && !rd_needs_close && !hit_conflict &&
                    (st_comb ? (hit_any || free_any) : (!busy && fifo_in_ready));
  assign st_take = st_valid && st_ready && st_comb;
  assign st_dst = hit_any ? hit_idx : free_idx;

  ////////////////////////////////////////////////////////////////////////////
  // drain engine waits for the oldest busy buffer to close, then sends it
  wcb_pkg::wcb_state_e state, next_state;
  logic [CMD_W-1:0] fifo_in_data;
  logic bypass;
  logic drain_fire;

  assign bypass = st_valid && st_ready && !st_comb;
  assign drain_fire = (state == wcb_pkg::WCB_EMIT) && fifo_in_ready && !bypass;

  always_comb begin
    next_state = state;
    case (state)
      wcb_pkg::WCB_IDLE: if (busy) next_state = wcb_pkg::WCB_PICK;
      wcb_pkg::WCB_PICK: next_state = buf_closed[old_idx] ? wcb_pkg::WCB_EMIT :
                                      (busy ? wcb_pkg::WCB_PICK : wcb_pkg::WCB_IDLE);
      wcb_pkg::WCB_EMIT: if (drain_fire) next_state = wcb_pkg::WCB_IDLE;
      default: next_state = wcb_pkg::WCB_IDLE;
    endcase
  end

  // one command per buffer: a full mask marks a single 64-byte write
  always_comb begin
    fifo_in_valid = 1'b0;
    fifo_in_data = '0;
    if (bypass) begin
      fifo_in_valid = 1'b1;
      fifo_in_data = {st_line, st_lanes, st_wide, 1'b0};
    end else if (state == wcb_pkg::WCB_EMIT) begin
      fifo_in_valid = 1'b1;
      fifo_in_data = {buf_line[old_idx], buf_mask[old_idx], buf_data[old_idx],
                      buf_mask[old_idx] == wcb_pkg::MASK_FULL};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= wcb_pkg::WCB_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // buffer update: merge, open, close, release
  always_comb begin
    for (int i = 0; i < NUM_BUF; i++) begin
      next_open[i] = buf_open[i];
      next_closed[i] = buf_closed[i];
      next_line[i] = buf_line[i];
      next_mask[i] = buf_mask[i];
      next_strm[i] = buf_strm[i];
      next_buf_age[i] = buf_age[i];
      next_data[i] = buf_data[i];
      // every listed event closes every open buffer, streaming or not
      if (buf_open[i] && (evt_any || rd_needs_close)) begin
        next_open[i] = 1'b0;
        next_closed[i] = 1'b1;
      end
      if (st_valid && hit_conflict && !evt_any && hit_idx == IDX_W'(i)) begin
        next_open[i] = 1'b0;
        next_closed[i] = 1'b1;
      end
      // a sent buffer leaves the queue and every younger one moves up a rank;
      // ranks stay below the pool size, so the order can never wrap
      if (drain_fire && old_idx == IDX_W'(i)) begin
        next_closed[i] = 1'b0;
        next_mask[i] = wcb_pkg::MASK_EMPTY;
      end else if (drain_fire && (buf_open[i] || buf_closed[i])) begin
        next_buf_age[i] = buf_age[i] - 1'b1;
      end
      // merge into the hit buffer, or open a new stream in a free slot
      if (st_take && st_dst == IDX_W'(i)) begin
        for (int b = 0; b < wcb_pkg::LINE_BYTES; b++) begin
          if (st_lanes[b]) begin
            next_data[i][b*wcb_pkg::LANE_W +: wcb_pkg::LANE_W] =
              st_wide[b*wcb_pkg::LANE_W +: wcb_pkg::LANE_W];
          end
        end
        next_mask[i] = (hit_any ? buf_mask[i] : wcb_pkg::MASK_EMPTY) | st_lanes;
        if (next_mask[i] == wcb_pkg::MASK_FULL) begin
          next_open[i] = 1'b0;
          next_closed[i] = 1'b1;
        end else begin
          next_open[i] = 1'b1;
        end
        if (!hit_any) begin
          next_line[i] = st_line;
          next_strm[i] = st_streaming;
          // youngest rank: behind every buffer that is still left after this edge
          next_buf_age[i] = n_busy - (IDX_W + 1)'(drain_fire);
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_BUF; i++) begin
        buf_open[i] <= 1'b0;
        buf_closed[i] <= 1'b0;
        buf_line[i] <= '0;
        buf_mask[i] <= wcb_pkg::MASK_EMPTY;
        buf_strm[i] <= 1'b0;
        buf_age[i] <= '0;
        buf_data[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_BUF; i++) begin
        buf_open[i] <= next_open[i];
        buf_closed[i] <= next_closed[i];
        buf_line[i] <= next_line[i];
        buf_mask[i] <= next_mask[i];
        buf_strm[i] <= next_strm[i];
        buf_age[i] <= next_buf_age[i];
        buf_data[i] <= next_data[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // count of buffers not yet sent
  always_comb begin
    open_count = '0;
    for (int i = 0; i < NUM_BUF; i++) begin
      open_count = open_count + (IDX_W + 1)'(buf_open[i] || buf_closed[i]);
    end
  end

  // outgoing command queue; interconnect back-pressure stalls the drain
  logic [CMD_W-1:0] fifo_out_data;

  wcb_fifo #(
    .WIDTH(CMD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_cmd_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(cmd_valid),
    .out_ready(cmd_ready),
    .out_data(fifo_out_data)
  );

  assign cmd_full_line = fifo_out_data[0];
  assign cmd_data = fifo_out_data[wcb_pkg::CMD_DATA_W:1];
  assign cmd_mask = fifo_out_data[wcb_pkg::CMD_DATA_W+wcb_pkg::LINE_BYTES:wcb_pkg::CMD_DATA_W+1];
  assign cmd_line = fifo_out_data[CMD_W-1:CMD_W-wcb_pkg::LINE_W];

endmodule : wcb_unit

/* testbench/wcb_unit_asserts.sv */
// wcb_unit_asserts: port-level checks on the write-combining unit
// assumes: bound into wcb_unit, one clock, rst asynchronous active high
`timescale 1ns/1ps
module wcb_unit_asserts #(
  parameter int NUM_BUF = 4,
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic st_valid,
  input wire logic st_ready,
  input wire logic [wcb_pkg::ADDR_W-1:0] st_addr,
  input wire logic [1:0] st_size,
  input wire logic [wcb_pkg::DATA_W-1:0] st_data,
  input wire wcb_pkg::wcb_mtype_e st_type,
  input wire logic st_streaming,
  input wire logic rd_valid,
  input wire logic [wcb_pkg::ADDR_W-1:0] rd_addr,
  input wire wcb_pkg::wcb_mtype_e rd_type,
  input wire logic rd_done,
  input wire logic evt_io,
  input wire logic evt_serialize,
  input wire logic evt_flush,
  input wire logic evt_lock,
  input wire logic evt_ad_set,
  input wire logic evt_done,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [wcb_pkg::LINE_W-1:0] cmd_line,
  input wire logic [wcb_pkg::LINE_BYTES-1:0] cmd_mask,
  input wire logic [wcb_pkg::CMD_DATA_W-1:0] cmd_data,
  input wire logic cmd_full_line,
  input wire logic [wcb_pkg::BUF_IDX_W:0] open_count
);
  logic any_evt;
  logic new_line;
  // any closing event held; a fresh non-streaming combining-type store into an empty pool
  assign any_evt = evt_io | evt_serialize | evt_flush | evt_lock | evt_ad_set;
  assign new_line = st_valid && st_ready && open_count == 0 && !st_streaming
    && st_type == wcb_pkg::WCB_COMBINING_TYPE;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_evt_refuse: assert property (any_evt |-> !st_ready)
    else $error("store accepted while an event is held");
  a_done_empty: assert property (evt_done |-> any_evt && open_count == 0)
    else $error("event done while buffers remain");
  a_flush_bound: assert property (evt_flush && !evt_done |-> ##[1:400] evt_done)
    else $error("flush never completed");
  a_full_flag: assert property (cmd_valid |-> cmd_full_line == (&cmd_mask))
    else $error("full-line flag disagrees with mask");
  a_cmd_hold: assert property (cmd_valid && !cmd_ready |=>
    cmd_valid && $stable(cmd_line) && $stable(cmd_mask))
    else $error("command changed while stalled");
  a_mask_live: assert property (cmd_valid |-> cmd_mask != 64'h0)
    else $error("command with empty mask");
  a_pool_limit: assert property (open_count <= 3'(NUM_BUF))
    else $error("more buffers than the pool holds");
  a_uc_read: assert property (rd_valid && rd_type == wcb_pkg::WCB_UNCACHEABLE_TYPE
    && open_count != 0 |-> !rd_done)
    else $error("uncacheable read passed open buffers");
  a_rd_free: assert property (rd_valid && open_count == 0 |-> rd_done)
    else $error("read held with nothing open");
  a_open_one: assert property (new_line |=> open_count == 1)
    else $error("store did not open one buffer");
  // main scenarios reached
  c_flush: cover property (evt_flush && evt_done);
  c_full: cover property (cmd_valid && cmd_ready && cmd_full_line);
  c_pool: cover property (open_count == 3'h4);
  c_read: cover property (rd_valid && rd_done);
endmodule : wcb_unit_asserts

bind wcb_unit wcb_unit_asserts #(.NUM_BUF(NUM_BUF), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
  .clk(clk), .rst(rst), .st_valid(st_valid), .st_ready(st_ready), .st_addr(st_addr),
  .st_size(st_size), .st_data(st_data), .st_type(st_type), .st_streaming(st_streaming),
  .rd_valid(rd_valid), .rd_addr(rd_addr), .rd_type(rd_type), .rd_done(rd_done),
  .evt_io(evt_io), .evt_serialize(evt_serialize), .evt_flush(evt_flush),
  .evt_lock(evt_lock), .evt_ad_set(evt_ad_set), .evt_done(evt_done),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_line(cmd_line), .cmd_mask(cmd_mask),
  .cmd_data(cmd_data), .cmd_full_line(cmd_full_line), .open_count(open_count)
);

/* testbench/wcb_sink.sv */
// wcb_sink: interconnect model taking write commands and logging them
// assumes: same clock as the unit; slow throttles acceptance
`timescale 1ns/1ps
module wcb_sink (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [wcb_pkg::LINE_W-1:0] cmd_line,
  input wire logic [wcb_pkg::LINE_BYTES-1:0] cmd_mask,
  input wire logic [wcb_pkg::CMD_DATA_W-1:0] cmd_data,
  input wire logic cmd_full_line
);
  logic [1:0] cnt;
  logic [610:0] q[$];
  // ready one cycle in four when slow, so the drain really backs up
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 2'h0;
      cmd_ready <= 1'b0;
    end else begin
      cnt <= cnt + 2'h1;
      cmd_ready <= !slow || cnt == 2'h3;
      if (cmd_valid && cmd_ready) begin
        q.push_back({cmd_full_line, cmd_line, cmd_mask, cmd_data});
      end
    end
  end
endmodule : wcb_sink

/* testbench/tb.sv */
// tb: self-checking bench for the write-combining unit
// assumes: wcb_sink on the command side, everything else driven here
`timescale 1ns/1ps
module tb;
  localparam wcb_pkg::wcb_mtype_e ct = wcb_pkg::WCB_COMBINING_TYPE;
  localparam wcb_pkg::wcb_mtype_e wbt = wcb_pkg::WCB_WRITEBACK_TYPE;
  localparam wcb_pkg::wcb_mtype_e uct = wcb_pkg::WCB_UNCACHEABLE_TYPE;
  localparam logic [63:0] dat = 64'h8877665544332211;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic st_valid, st_streaming, rd_valid, slow;
  logic [39:0] st_addr, rd_addr;
  logic [1:0] st_size;
  logic [63:0] st_data;
  wcb_pkg::wcb_mtype_e st_type, rd_type;
  logic [4:0] ev;
  logic st_ready, rd_done, evt_done, cmd_valid, cmd_ready, cmd_full_line;
  logic [33:0] cmd_line;
  logic [63:0] cmd_mask;
  logic [511:0] cmd_data;
  logic [2:0] open_count;
  logic [610:0] c;
  int n_errors = 0;
  int checks = 0;

  always #10 clk = ~clk;

  wcb_unit u_wcb_unit (.clk(clk), .rst(rst), .st_valid(st_valid), .st_ready(st_ready),
    .st_addr(st_addr), .st_size(st_size), .st_data(st_data), .st_type(st_type),
    .st_streaming(st_streaming), .rd_valid(rd_valid), .rd_addr(rd_addr), .rd_type(rd_type),
    .rd_done(rd_done), .evt_io(ev[0]), .evt_serialize(ev[1]), .evt_flush(ev[2]),
    .evt_lock(ev[3]), .evt_ad_set(ev[4]), .evt_done(evt_done), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_line(cmd_line), .cmd_mask(cmd_mask), .cmd_data(cmd_data),
    .cmd_full_line(cmd_full_line), .open_count(open_count));
  wcb_sink u_wcb_sink (.clk(clk), .rst(rst), .slow(slow), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_line(cmd_line), .cmd_mask(cmd_mask), .cmd_data(cmd_data),
    .cmd_full_line(cmd_full_line));

  ////////////////////////////////////////////////////////////////////////////
  task automatic step();
    @(posedge clk);
    #1;
  endtask : step

  task automatic stop_test();
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic hung(input string n);
    n_errors++;
    $display("mismatch %s expected done seen timeout", n);
    stop_test();
  endtask : hung

  // one store, held until accepted; a refusal just stretches the wait
  task automatic store(input logic [39:0] a, input logic [1:0] sz,
      input wcb_pkg::wcb_mtype_e ty, input logic s);
    int i;
    st_addr = a;
    st_size = sz;
    st_data = dat;
    st_type = ty;
    st_streaming = s;
    st_valid = 1'b1;
    // look at the accept only once it has settled on the new request
    #1;
    for (i = 0; i < 300 && st_ready !== 1'b1; i++) begin
      step();
      #1;
    end
    if (i == 300) hung("st_ready");
    step();
    st_valid = 1'b0;
    step();
  endtask : store

  // k below 5 holds that event, 5 holds the read, until its done level
  task automatic req(input int k);
    int i;
    if (k < 5) ev = 5'h1 << k;
    else rd_valid = 1'b1;
    for (i = 0; i < 400 && (k < 5 ? evt_done : rd_done) !== 1'b1; i++)
      step();
    if (i == 400) hung("done");
    step();
    ev = 5'h0;
    rd_valid = 1'b0;
    step();
  endtask : req

  task automatic expect_cmd(input logic [39:0] a, input logic [63:0] m, input logic f);
    int i;
    for (i = 0; i < 300 && u_wcb_sink.q.size() == 0; i++)
      step();
    if (i == 300) hung("cmd");
    c = u_wcb_sink.q.pop_front();
    chk("cmd_line", 64'(c[609:576]), 64'(a[39:6]));
    chk("cmd_mask", c[575:512], m);
    chk("cmd_full_line", 64'(c[610]), 64'(f));
  endtask : expect_cmd

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_sizes();
    for (int s = 0; s < 4; s++)
      store(40'h1000 + 40'(8 * s), 2'(s), ct, 1'b0);
    chk("cmd_valid", 64'(cmd_valid), 64'h0);
    chk("open_count", 64'(open_count), 64'h1);
    req(2);
    expect_cmd(40'h1000, 64'hff0f0301, 1'b0);
    chk("lane25", 64'(c[207:200]), 64'h22);
  endtask : t_sizes

  // reverse order fill closes by itself, no event
  task automatic t_full();
    for (int i = 7; i >= 0; i--)
      store(40'h2000 + 40'(8 * i), 2'h3, ct, 1'b0);
    expect_cmd(40'h2000, wcb_pkg::MASK_FULL, 1'b1);
    chk("lane9", 64'(c[79:72]), 64'h22);
  endtask : t_full

  task automatic t_order();
    store(40'h3040, 2'h0, ct, 1'b0);
    store(40'h3000, 2'h0, ct, 1'b0);
    store(40'h3080, 2'h0, wbt, 1'b1);
    store(40'h3081, 2'h0, wbt, 1'b1);
    store(40'h30c0, 2'h0, ct, 1'b0);
    chk("open_count", 64'(open_count), 64'h4);
    slow = 1'b1;
    req(1);
    expect_cmd(40'h3040, 64'h1, 1'b0);
    expect_cmd(40'h3000, 64'h1, 1'b0);
    expect_cmd(40'h3080, 64'h3, 1'b0);
    expect_cmd(40'h30c0, 64'h1, 1'b0);
    slow = 1'b0;
  endtask : t_order

  task automatic t_events();
    for (int k = 0; k < 5; k++) begin
      store(40'h4000 + 40'(64 * k), 2'h0, k[0] ? wbt : ct, k[0]);
      req(k);
      expect_cmd(40'h4000 + 40'(64 * k), 64'h1, 1'b0);
    end
  endtask : t_events

  task automatic t_reads();
    store(40'h5000, 2'h0, ct, 1'b0);
    rd_type = ct;
    rd_addr = 40'h5040;
    req(5);
    chk("open_count", 64'(open_count), 64'h1);
    rd_addr = 40'h5010;
    req(5);
    expect_cmd(40'h5000, 64'h1, 1'b0);
    store(40'h5000, 2'h0, ct, 1'b0);
    rd_type = uct;
    rd_addr = 40'h9000;
    req(5);
    expect_cmd(40'h5000, 64'h1, 1'b0);
  endtask : t_reads

  task automatic t_mix();
    store(40'h6000, 2'h0, wbt, 1'b1);
    store(40'h6001, 2'h0, ct, 1'b0);
    expect_cmd(40'h6000, 64'h1, 1'b0);
    req(2);
    expect_cmd(40'h6000, 64'h2, 1'b0);
    store(40'h7003, 2'h0, uct, 1'b0);
    expect_cmd(40'h7000, 64'h8, 1'b0);
    chk("open_count", 64'(open_count), 64'h0);
  endtask : t_mix

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    st_valid = 1'b0;
    st_streaming = 1'b0;
    rd_valid = 1'b0;
    slow = 1'b0;
    st_addr = 40'h0;
    rd_addr = 40'h0;
    st_size = 2'h0;
    st_data = 64'h0;
    st_type = ct;
    rd_type = ct;
    ev = 5'h0;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    t_sizes();
    t_full();
    t_order();
    t_events();
    t_reads();
    t_mix();
    stop_test();
  end
endmodule : tb
